// file: core/tcs_defs.vh
`ifndef TCS_DEFS_VH
`define TCS_DEFS_VH

// register pointers
`define TCS_PTR_CONFIG 8'h30
`define TCS_PTR_RESULT_BASE 8'h00

// configuration field positions
`define TCS_REM_EN_HI 11
`define TCS_REM_EN_LO 8
`define TCS_LOC_EN_BIT 7
`define TCS_SINGLE_BIT 6
`define TCS_SHUT_BIT 5
`define TCS_RATE_HI 4
`define TCS_RATE_LO 2
`define TCS_BUSY_BIT 1
`define TCS_RESV0_BIT 0

// reset values
`define TCS_CONFIG_RST 16'h0F9C
`define TCS_RATE_B2B 3'h7

// timing: conversion times in microseconds (tenths of a ms as printed)
`define TCS_CLK_HZ 25000000
`define TCS_LOC_CONV_US 15500
`define TCS_REM_CONV_US 15800
// slowest cycle period, 16 s, in microseconds
`define TCS_SLOW_PERIOD_US 16000000
// pipeline cycles around each conversion and each idle gap
`define TCS_CONV_OVH_CYC 2
`define TCS_IDLE_OVH_CYC 3

`endif

// file: core/tcs_conv_timer.v
`timescale 1ns/1ns
// conversion and idle countdown timer; one load, one done pulse
module tcs_conv_timer #(
  parameter CW = 29
) (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire load,
  input wire abort,
  input wire [CW-1:0] count,
  // status
  output reg running_q,
  output reg done_q
);
  reg [CW-1:0] cnt_q;

  ////////////////////////////////////////////////////////////////////////
  // load wins over a running count; abort kills it silently
  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= {CW{1'b0}};
      running_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (abort)
      begin
        running_q <= 1'b0;
        cnt_q <= {CW{1'b0}};
      end
      else if (load)
      begin
        cnt_q <= count;
        running_q <= 1'b1;
      end
      else if (running_q)
      begin
        if (cnt_q <= {{(CW-1){1'b0}}, 1'b1})
        begin
          running_q <= 1'b0;
          done_q <= 1'b1;
        end
        else
          cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // tcs_conv_timer

// file: core/tcs_sequencer.v
`timescale 1ns/1ns
`include "tcs_defs.vh"

module tcs_sequencer #(
  parameter LOC_CONV_CYC = (`TCS_LOC_CONV_US * (`TCS_CLK_HZ / 1000000)),
  parameter REM_CONV_CYC = (`TCS_REM_CONV_US * (`TCS_CLK_HZ / 1000000)),
  parameter SLOW_CYC = (`TCS_SLOW_PERIOD_US * (`TCS_CLK_HZ / 1000000))
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RST,
  // register port from the two-wire serial front end
  input wire [7:0] REG_PTR,
  input wire REG_WR,
  input wire [15:0] REG_WDATA,
  input wire REG_RD,
  output reg [15:0] REG_RDATA,
  // converter data path
  input wire [15:0] ADC_RESULT,
  output reg [2:0] ADC_CHANNEL,
  output reg ADC_ACTIVE,
  output reg RESULT_WE,
  output reg [2:0] RESULT_CHANNEL,
  output reg [15:0] RESULT_DATA
);
  localparam CW = 29;
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CONV = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [2:0] CH_LOCAL = 3'h0;
  // handshake cycles, taken off the idle gap so the period stays exact
  localparam [CW-1:0] CONV_OVH = `TCS_CONV_OVH_CYC;
  localparam [CW-1:0] IDLE_OVH = `TCS_IDLE_OVH_CYC;

  reg [3:0] remote_channel_enables_q;
  reg local_channel_enable_q;
  reg single_shot_request_q;
  reg shutdown_request_q;
  reg [2:0] cycle_rate_field_q;
  reg [1:0] state_q;
  reg [2:0] chan_q;
  reg [CW-1:0] cycle_cnt_q;
  reg [15:0] result_mem_q [0:4];
  reg tmr_load;
  reg [CW-1:0] tmr_count;
  wire tmr_running;
  wire tmr_done;
  wire [4:0] enables;
  wire halted;
  wire wr_cfg;
  wire start_single;
  integer i;

  // enable vector indexed by channel: 0 local, 1..4 remote one..four
  assign enables = {remote_channel_enables_q, local_channel_enable_q};
  // shutdown, or nothing enabled, both mean no continuous work
  assign halted = shutdown_request_q || (enables == 5'h00);
  assign wr_cfg = REG_WR && (REG_PTR == `TCS_PTR_CONFIG);
  assign start_single = wr_cfg && REG_WDATA[`TCS_SINGLE_BIT]
    && REG_WDATA[`TCS_SHUT_BIT]
    && (REG_WDATA[`TCS_REM_EN_HI:`TCS_LOC_EN_BIT] != 5'h00)
    && (state_q == ST_IDLE) && shutdown_request_q;

  ////////////////////////////////////////////////////////////////////////
  // next enabled channel after cur in round-robin order, wrapping
  function [2:0] next_chan;
    input [2:0] cur;
    input [4:0] en;
    reg [2:0] k;
    reg found;
    integer j;
    begin
      next_chan = CH_LOCAL;
      found = 1'b0;
      k = cur;
      for (j = 0; j < 5; j = j + 1)
      begin
        k = (k == 3'h4) ? 3'h0 : k + 3'h1;
        if (!found && en[k])
        begin
          next_chan = k;
          found = 1'b1;
        end
      end
    end
  endfunction

  // first enabled channel of a cycle, searched from local
  function [2:0] first_chan;
    input [4:0] en;
    begin
      first_chan = next_chan(3'h4, en);
    end
  endfunction

  // conversion length of one channel; local and remote differ
  function [CW-1:0] conv_len;
    input [2:0] ch;
    begin
      if (ch == CH_LOCAL)
        conv_len = LOC_CONV_CYC[CW-1:0];
      else
        conv_len = REM_CONV_CYC[CW-1:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  tcs_conv_timer #(
    .CW(CW)
  ) u_timer (
    .clk(CLK_SYS),
    .rst(RST),
    .load(tmr_load),
    .abort(wr_cfg && REG_WDATA[`TCS_SHUT_BIT]),
    .count(tmr_count),
    .running_q(tmr_running),
    .done_q(tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // configuration register; reserved and busy bits are not stored
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      remote_channel_enables_q <= 4'hF;
      local_channel_enable_q <= 1'b1;
      single_shot_request_q <= 1'b0;
      shutdown_request_q <= 1'b0;
      cycle_rate_field_q <= `TCS_RATE_B2B;
    end
    else if (wr_cfg)
    begin
      remote_channel_enables_q <= REG_WDATA[`TCS_REM_EN_HI:`TCS_REM_EN_LO];
      local_channel_enable_q <= REG_WDATA[`TCS_LOC_EN_BIT];
      // all enables zero reads back as shutdown
      shutdown_request_q <= REG_WDATA[`TCS_SHUT_BIT]
        || (REG_WDATA[`TCS_REM_EN_HI:`TCS_LOC_EN_BIT] == 5'h00);
      cycle_rate_field_q <= REG_WDATA[`TCS_RATE_HI:`TCS_RATE_LO];
      // a request out of shutdown never latches
      single_shot_request_q <= start_single;
    end
    else if (single_shot_request_q && state_q == ST_IDLE
      && cycle_cnt_q != {CW{1'b0}})
      single_shot_request_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer: idle, converting one channel, idle gap between cycles
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      state_q <= ST_IDLE;
      chan_q <= CH_LOCAL;
      cycle_cnt_q <= {CW{1'b0}};
      tmr_load <= 1'b0;
      tmr_count <= {CW{1'b0}};
      RESULT_WE <= 1'b0;
      RESULT_CHANNEL <= CH_LOCAL;
      RESULT_DATA <= 16'h0000;
      for (i = 0; i < 5; i = i + 1)
        result_mem_q[i] <= 16'h0000;
    end
    else
    begin
      tmr_load <= 1'b0;
      RESULT_WE <= 1'b0;
      if (wr_cfg && REG_WDATA[`TCS_SHUT_BIT])
      begin
        // abort mid-conversion; result of it is dropped
        state_q <= ST_IDLE;
        chan_q <= CH_LOCAL;
        cycle_cnt_q <= {CW{1'b0}};
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            cycle_cnt_q <= {CW{1'b0}};
            // the write edge itself aborts, so a latched pass starts here
            if ((!halted && !single_shot_request_q)
              || (single_shot_request_q && cycle_cnt_q == {CW{1'b0}}))
            begin
              // always restart a cycle from the first enabled channel
              chan_q <= first_chan(wr_cfg ?
                REG_WDATA[`TCS_REM_EN_HI:`TCS_LOC_EN_BIT] : enables);
              state_q <= ST_CONV;
              tmr_count <= conv_len(first_chan(wr_cfg ?
                REG_WDATA[`TCS_REM_EN_HI:`TCS_LOC_EN_BIT] : enables));
              tmr_load <= 1'b1;
            end
          end
          ST_CONV:
          begin
            if (tmr_done)
            begin
              result_mem_q[chan_q] <= ADC_RESULT;
              RESULT_WE <= 1'b1;
              RESULT_CHANNEL <= chan_q;
              RESULT_DATA <= ADC_RESULT;
              if (next_chan(chan_q, enables) > chan_q && enables != 5'h00)
              begin
                // skip disabled channels within the cycle
                chan_q <= next_chan(chan_q, enables);
                tmr_count <= conv_len(next_chan(chan_q, enables));
                tmr_load <= 1'b1;
                cycle_cnt_q <= cycle_cnt_q + conv_len(chan_q) + CONV_OVH;
              end
              else if (single_shot_request_q)
              begin
                // pass done; mark it so the bit clears
                state_q <= ST_IDLE;
                cycle_cnt_q <= {{(CW-1){1'b0}}, 1'b1};
              end
              else if (cycle_rate_field_q == `TCS_RATE_B2B)
              begin
                state_q <= ST_IDLE;
              end
              else
              begin
                // idle fills the rest of the period; conversion untouched
                state_q <= ST_WAIT;
                tmr_count <= idle_len(cycle_cnt_q + conv_len(chan_q)
                  + CONV_OVH);
                tmr_load <= 1'b1;
              end
            end
          end
          ST_WAIT:
          begin
            if (tmr_done || halted)
              state_q <= ST_IDLE;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // idle time = period (16 s >> code) minus time spent converting
  function [CW-1:0] idle_len;
    input [CW-1:0] spent;
    reg [CW-1:0] period;
    begin
      period = SLOW_CYC[CW-1:0] >> cycle_rate_field_q;
      if (period > spent + IDLE_OVH + {{(CW-1){1'b0}}, 1'b1})
        idle_len = period - spent - IDLE_OVH;
      else
        idle_len = {{(CW-1){1'b0}}, 1'b1};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registered outputs: read data, converter steering
  always @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      REG_RDATA <= 16'h0000;
      ADC_CHANNEL <= CH_LOCAL;
      ADC_ACTIVE <= 1'b0;
    end
    else
    begin
      ADC_CHANNEL <= chan_q;
      ADC_ACTIVE <= (state_q == ST_CONV) && !(wr_cfg
        && REG_WDATA[`TCS_SHUT_BIT]);
      if (REG_RD)
      begin
        if (REG_PTR == `TCS_PTR_CONFIG)
          REG_RDATA <= {4'h0, remote_channel_enables_q,
            local_channel_enable_q, single_shot_request_q,
            shutdown_request_q, cycle_rate_field_q,
            (state_q == ST_CONV), 1'b0};
        else if (REG_PTR < 8'h05)
          REG_RDATA <= result_mem_q[REG_PTR[2:0]];
        else
          REG_RDATA <= 16'h0000;
      end
    end
  end
endmodule // tcs_sequencer

// file: test/tcs_monitor.sv
`timescale 1ns/1ns
// port-level checker for the conversion sequencer
module tcs_monitor #(
  parameter REM_CONV_CYC = 24
) (
  // clock and reset
  input wire CLK_SYS,
  input wire RST,
  // register port
  input wire [7:0] REG_PTR,
  input wire REG_WR,
  input wire [15:0] REG_WDATA,
  input wire REG_RD,
  input wire [15:0] REG_RDATA,
  // converter side
  input wire [2:0] ADC_CHANNEL,
  input wire ADC_ACTIVE,
  input wire RESULT_WE,
  input wire [2:0] RESULT_CHANNEL
);
  reg shut_q;
  reg [31:0] run_q;
  wire cfg_rd = REG_RD && REG_PTR == 8'h30;
  wire cfg_wr = REG_WR && REG_PTR == 8'h30;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////
  // halt as last written; a single-shot write means a pass
  always @(posedge CLK_SYS)
  begin
    if (RST)
      shut_q <= 1'b0;
    else if (cfg_wr)
      shut_q <= REG_WDATA[5] && !REG_WDATA[6];
  end
  // cycles spent in the running conversion
  always @(posedge CLK_SYS)
  begin
    if (RST || !ADC_ACTIVE || RESULT_WE)
      run_q <= 32'h00000000;
    else
      run_q <= run_q + 32'h00000001;
  end
  ////////////////////////////////////////////////////////////
  property p_rsv;
    cfg_rd |=> REG_RDATA[15:12] == 4'h0 && !REG_RDATA[0];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_rst;
    $fell(RST) |-> REG_RDATA == 16'h0000 && !ADC_ACTIVE && !RESULT_WE;
  endproperty
  a_rst: assert property (p_rst) else $error("reset outputs");
  property p_halt;
    shut_q |-> !ADC_ACTIVE;
  endproperty
  a_halt: assert property (p_halt) else $error("active in halt");
  property p_halt_rd;
    shut_q && cfg_rd |=> REG_RDATA[5] && !REG_RDATA[1];
  endproperty
  a_halt_rd: assert property (p_halt_rd) else $error("busy in halt");
  property p_restart;
    cfg_wr && shut_q && !REG_WDATA[5] && REG_WDATA[7]
      |-> ##[1:6] ADC_ACTIVE && ADC_CHANNEL == 3'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("restart");
  property p_src;
    RESULT_WE |-> $past(ADC_ACTIVE) && RESULT_CHANNEL == $past(ADC_CHANNEL);
  endproperty
  a_src: assert property (p_src) else $error("result source");
  property p_chan;
    ADC_ACTIVE |-> ADC_CHANNEL <= 3'h4;
  endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  // rate code never stretches a conversion
  property p_len;
    ADC_ACTIVE |-> run_q <= REM_CONV_CYC + 1;
  endproperty
  a_len: assert property (p_len) else $error("long conversion");
endmodule // tcs_monitor

bind tcs_sequencer tcs_monitor #(.REM_CONV_CYC(REM_CONV_CYC)) u_mon (
  .CLK_SYS(CLK_SYS), .RST(RST), .REG_PTR(REG_PTR), .REG_WR(REG_WR),
  .REG_WDATA(REG_WDATA), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .ADC_CHANNEL(ADC_CHANNEL), .ADC_ACTIVE(ADC_ACTIVE),
  .RESULT_WE(RESULT_WE), .RESULT_CHANNEL(RESULT_CHANNEL)
);

// file: test/tcs_host.sv
`timescale 1ns/1ns
// serial host front end plus converter result source
module tcs_host (
  // clock
  input wire clk,
  // register port
  output reg [7:0] reg_ptr,
  output reg reg_wr,
  output reg [15:0] reg_wdata,
  output reg reg_rd,
  input wire [15:0] reg_rdata,
  // converter
  input wire [2:0] adc_channel,
  output wire [15:0] adc_result
);
  // result pattern tells the channels apart
  assign adc_result = 16'h1230 + {13'h0000, adc_channel};
  // idle bus at time zero
  initial
  begin
    reg_ptr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // one word written; data line does not hold after release
  task write_word(input [7:0] p, input [15:0] v);
  begin
    @(negedge clk);
    reg_ptr = p;
    reg_wdata = v & 16'h0FFE;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  end
  endtask
  // one word read, data taken one cycle after the strobe
  task read_word(input [7:0] p, output [15:0] v);
  begin
    @(negedge clk);
    reg_ptr = p;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  end
  endtask
endmodule // tcs_host

// file: test/test_temp_conversion_sequencer.sv
`timescale 1ns/1ns
// self-checking bench; counts shortened for simulation
module test_temp_conversion_sequencer;
  localparam SLOW = 6400;
  reg clk = 1'b0;
  reg rst = 1'b1;
  wire [7:0] ptr;
  wire wr, rd, r_we, act;
  wire [15:0] wdat, rdat, adc, r_dat;
  wire [2:0] ach, r_ch;
  integer n_mismatch = 0;
  integer compares = 0;
  integer cyc = 0;
  integer t0, t1, i, k;
  reg [15:0] d;
  reg [2:0] c;
  ////////////////////////////////////////////////////////////
  tcs_sequencer #(.LOC_CONV_CYC(20), .REM_CONV_CYC(24), .SLOW_CYC(SLOW))
  u_dut (.CLK_SYS(clk), .RST(rst), .REG_PTR(ptr), .REG_WR(wr),
    .REG_WDATA(wdat), .REG_RD(rd), .REG_RDATA(rdat), .ADC_RESULT(adc),
    .ADC_CHANNEL(ach), .ADC_ACTIVE(act), .RESULT_WE(r_we),
    .RESULT_CHANNEL(r_ch), .RESULT_DATA(r_dat));
  tcs_host u_host (.clk(clk), .reg_ptr(ptr), .reg_wr(wr),
    .reg_wdata(wdat), .reg_rd(rd), .reg_rdata(rdat),
    .adc_channel(ach), .adc_result(adc));
  // 25 MHz clock and a cycle count for spacing checks
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////
  task check(input [15:0] seen, input [15:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  // next stored result: channel in c, cycle in t1
  task nxt;
  begin
    k = 0;
    @(negedge clk);
    while (r_we !== 1'b1 && k < 9000)
    begin
      @(negedge clk);
      k = k + 1;
    end
    check(r_we, 1'b1);
    c = r_ch;
    t1 = cyc;
    check(r_dat, 16'h1230 + c);
  end
  endtask
  // no result may appear for n cycles
  task quiet(input integer n);
  begin
    k = 0;
    repeat (n)
    begin
      @(negedge clk);
      k = k + r_we;
    end
    check(k[15:0], 16'h0000);
  end
  endtask
  task tally_and_finish;
  begin
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////
  task t_reset;
  begin
    u_host.read_word(8'h30, d);
    check(d & 16'hFFFD, 16'h0F9C);
    check(d[1], 1'b1);
    u_host.read_word(8'h31, d);
    check(d, 16'h0000);
    nxt;
    check(c, 3'h0);
    nxt;
    check(c, 3'h1);
    $display("reset test done");
  end
  endtask
  // local, remote two and four only
  task t_order;
  begin
    u_host.write_word(8'h30, 16'h0A9C);
    nxt;
    while (c !== 3'h0) nxt;
    nxt;
    check(c, 3'h2);
    nxt;
    check(c, 3'h4);
    nxt;
    check(c, 3'h0);
    u_host.read_word(8'h04, d);
    check(d, 16'h1234);
    $display("order test done");
  end
  endtask
  // halt, with a write attempt on the busy bit
  task t_shut;
  begin
    u_host.write_word(8'h30, 16'h0FBE);
    check(act, 1'b0);
    quiet(200);
    u_host.read_word(8'h30, d);
    check(d, 16'h0FBC);
    u_host.write_word(8'h30, 16'h0F9C);
    nxt;
    check(c, 3'h0);
    u_host.write_word(8'h30, 16'h0FDC);
    u_host.read_word(8'h30, d);
    check(d & 16'hFFFD, 16'h0F9C);
    $display("halt test done");
  end
  endtask
  task t_single;
  begin
    u_host.write_word(8'h30, 16'h0FBC);
    u_host.write_word(8'h30, 16'h0FFC);
    u_host.read_word(8'h30, d);
    check(d[6], 1'b1);
    for (i = 0; i < 5; i = i + 1)
    begin
      nxt;
      check(c, i[2:0]);
    end
    repeat (4) @(negedge clk);
    u_host.read_word(8'h30, d);
    check(d, 16'h0FBC);
    quiet(300);
    $display("single test done");
  end
  endtask
  // local only, rate codes 3 to 6; then all channels off
  task t_rate;
  begin
    for (i = 3; i < 7; i = i + 1)
    begin
      u_host.write_word(8'h30, 16'h0080 | (i[15:0] << 2));
      nxt;
      nxt;
      t0 = t1;
      nxt;
      check(16'(t1 - t0), 16'(SLOW >> i));
    end
    u_host.write_word(8'h30, 16'h001C);
    repeat (100) @(negedge clk);
    quiet(300);
    u_host.read_word(8'h30, d);
    check(d, 16'h003C);
    $display("rate test done");
  end
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset;
    t_order;
    t_shut;
    t_single;
    t_rate;
    tally_and_finish;
  end
  // limit well above the expected run length
  initial
  begin
    #(40 * 40000);
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
endmodule // test_temp_conversion_sequencer
